// ### hw/vrc_params.svh
// Register offsets, field positions, reset values and timing of the conditioner
`ifndef VRC_PARAMS_SVH
`define VRC_PARAMS_SVH
`define VRC_CTRL_OFS 8'h00
`define VRC_STAT_OFS 8'h04
`define VRC_PGAIN_OFS 8'h08
`define VRC_NGAIN_OFS 8'h0C
`define VRC_PCOMP_OFS 8'h10
`define VRC_NCOMP_OFS 8'h14
`define VRC_THR_OFS 8'h18
`define VRC_OFFS_OFS 8'h1C
`define VRC_RPOS_OFS 8'h20
`define VRC_RNEG_OFS 8'h24
`define VRC_DITH_OFS 8'h28
`define VRC_LIN_OFS 8'h2C
`define VRC_FBREF_OFS 8'h30
`define VRC_CMD_OFS 8'h34
`define VRC_CTRL_SRC 0
`define VRC_CTRL_BIAS 1
`define VRC_CTRL_RAMP 2
`define VRC_CTRL_RMODE 3
`define VRC_CTRL_DITH 5
`define VRC_CTRL_MON 6
`define VRC_LIN_IDX 16
`define VRC_GAIN_RST 16'h8000
`define VRC_COMP_RST 15'h0000
`define VRC_THR_RST 15'h0000
`define VRC_OFFS_RST 16'h0000
`define VRC_RATE_RST 16'h0100
`define VRC_DAMP_RST 16'h0100
`define VRC_DHALF_RST 16'h0004
`define VRC_LIN_STEP 4096
`define VRC_CLK_NS 4
`define VRC_TICK_NS 1000
`define VRC_PWRUP_MS 270
`endif

// ### hw/vrc_pkg.sv
// Types and helpers shared by the conditioner modules
package vrc_pkg;
    typedef enum logic [1:0] {
        VRC_RAMP_SINGLE = 2'b00,
        VRC_RAMP_DUAL = 2'b01,
        VRC_RAMP_QUAD = 2'b10,
        VRC_RAMP_QUAD_ALT = 2'b11
    } vrc_ramp_mode_e;
    typedef enum logic [1:0] {
        VRC_MON_SPOOL = 2'b00,
        VRC_MON_ANALOG = 2'b01,
        VRC_MON_FIELDBUS = 2'b10,
        VRC_MON_PILOT = 2'b11
    } vrc_mon_e;
    typedef struct packed {
        logic [15:0] cur;
    } vrc_ramp_s;
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic src_fb;
        logic bias_en;
        logic ramp_en;
        vrc_ramp_mode_e ramp_mode;
        logic dith_en;
        vrc_mon_e mon_sel;
        logic [15:0] pos_gain;
        logic [15:0] neg_gain;
        logic [14:0] pos_comp;
        logic [14:0] neg_comp;
        logic [14:0] thr;
        logic [15:0] offset;
        logic [15:0] fb_ref;
        logic [3:0][15:0] rates;
        logic [15:0] dith_amp;
        logic [15:0] dith_half;
        logic [3:0] lin_idx;
        logic [8:0][15:0] lin;
        logic [15:0] s_bias;
        logic [15:0] s_scale;
        logic [15:0] s_lin;
        logic [15:0] cmd;
        logic [7:0] tick_cnt;
        logic tick;
        logic [15:0] dith_cnt;
        logic dith_ph;
        logic [26:0] pwr_cnt;
        logic ready;
        logic sol_en;
        logic fault;
        logic [15:0] monitor;
    } vrc_main_s;
    function automatic logic [15:0] vrc_sat16(input logic signed [31:0] v);
        if (v > 32'sh00007FFF) begin
            return 16'h7FFF;
        end else if (v < -32'sh00008000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : vrc_sat16
endpackage : vrc_pkg

// ### hw/vrc_ramp.sv
// Rate limiter between the scaled reference and the linearizer
`timescale 1ns/100ps
`default_nettype none
module vrc_ramp
    import vrc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic ramp_en,
    input wire vrc_ramp_mode_e ramp_mode,
    input wire logic [15:0] rate_rise_pos,
    input wire logic [15:0] rate_fall_pos,
    input wire logic [15:0] rate_rise_neg,
    input wire logic [15:0] rate_fall_neg,
    input wire logic [15:0] target,
    output logic [15:0] ramp_out
);
    vrc_ramp_s st;
    vrc_ramp_s nx;
    logic signed [31:0] t;
    logic signed [31:0] c;
    logic signed [31:0] d;
    logic signed [31:0] step;
    logic [15:0] rate;

    always_comb begin
        nx = st;
        t = 32'(signed'(target));
        c = 32'(signed'(st.cur));
        d = t - c;
        case (ramp_mode)
            VRC_RAMP_SINGLE: rate = rate_rise_pos;
            VRC_RAMP_DUAL: rate = (d > 0) ? rate_rise_pos : rate_fall_pos;
            default: begin
                // Sign of the present output picks the pair of rates
                if (c < 0) begin
                    rate = (d < 0) ? rate_rise_neg : rate_fall_neg;
                end else begin
                    rate = (d > 0) ? rate_rise_pos : rate_fall_pos;
                end
            end
        endcase
        step = 32'(rate);
        if (!ramp_en) begin
            nx.cur = target;
        end else if (tick) begin
            // A rate of zero freezes the output: left to software
            if (d > step) begin
                nx.cur = 16'(c + step);
            end else if (d < -step) begin
                nx.cur = 16'(c - step);
            end else begin
                nx.cur = target;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign ramp_out = st.cur;
endmodule : vrc_ramp
`default_nettype wire

// ### hw/vrc_conditioner.sv
// Valve reference conditioner with AHB-Lite registers and supervision
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "vrc_params.svh"
// Overview of operation
// - Monitor source selectable: spool position default, analog, fieldbus, pilot.
// - Enable low forces solenoid current off; logic keeps running.
// - While disabled, bus access and all other functions stay active.
// - Fault flagged on solenoid short/open, loop break or transducer break.
// - Fault output low on fault, high in normal operation.
// - Fault status is independent of the enable input.
// - Reference multiplied by programmable gain to limit maximum opening.
// - Separate gains for positive and negative references.
// - When active, deadband compensation is added to either reference source.
// - Compensation only while reference magnitude exceeds the threshold.
// - Separate compensation values for positive and negative references.
// - Programmable offset shifts centre position, resets to zero.
// - Ramp generator rate-limits steps of the reference.
// - Ramp modes: single rate, rise/fall rates, four sign/direction rates.
// - Ramp disabled at reset and switchable off by software.
// - Programmable linearization maps reference to commanded regulation.
// - Dither with selectable frequency and amplitude, off at reset.
// - Dither amplitude shrinks as reference magnitude grows.
// - Software selects analog input or fieldbus as reference source.
// - Solenoid current held off during the power-up interval.
module vrc_conditioner
    import vrc_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES =
        `VRC_PWRUP_MS * 1000000 / `VRC_CLK_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] analog_ref,
    input wire logic [15:0] spool_pos,
    input wire logic [15:0] pilot_pos,
    input wire logic enable_in,
    input wire logic sol_short,
    input wire logic sol_open,
    input wire logic loop_break,
    input wire logic xdcr_break,
    output logic [15:0] spool_cmd,
    output logic sol_current_en,
    output logic fault_n,
    output logic [15:0] monitor
);
    localparam int unsigned TICK_CYC = `VRC_TICK_NS / `VRC_CLK_NS;

    vrc_main_s st;
    vrc_main_s nx;
    logic [15:0] ramp_out;
    logic addr_ok;
    logic [15:0] src;
    logic signed [31:0] r_in;
    logic signed [31:0] r_mag;
    logic signed [31:0] b;
    logic signed [47:0] prod;
    logic signed [31:0] sc;
    logic signed [31:0] x;
    logic signed [31:0] xm;
    logic [3:0] k;
    logic [15:0] y0;
    logic [15:0] y1;
    logic signed [31:0] ly;
    logic signed [31:0] dm;
    logic [47:0] amp_prod;
    logic signed [31:0] amp;
    logic signed [31:0] dv;
    logic [31:0] rd;

    // Hsize is not checked: only whole-word accesses are expected
    assign addr_ok = (haddr[31:8] == 24'h000000);

    always_comb begin
        nx = st;
        // Address phase captured; write data lands one cycle later
        nx.wr_pend = hsel & htrans[1] & hready & hwrite & addr_ok;
        nx.rd_pend = hsel & htrans[1] & hready & ~hwrite & addr_ok;
        if (hsel && htrans[1] && hready) begin
            nx.addr = haddr[7:0];
        end
        if (st.wr_pend) begin
            case (st.addr)
                `VRC_CTRL_OFS: begin
                    nx.src_fb = hwdata[`VRC_CTRL_SRC];
                    nx.bias_en = hwdata[`VRC_CTRL_BIAS];
                    nx.ramp_en = hwdata[`VRC_CTRL_RAMP];
                    nx.ramp_mode =
                        vrc_ramp_mode_e'(hwdata[`VRC_CTRL_RMODE +: 2]);
                    nx.dith_en = hwdata[`VRC_CTRL_DITH];
                    nx.mon_sel = vrc_mon_e'(hwdata[`VRC_CTRL_MON +: 2]);
                end
                `VRC_PGAIN_OFS: nx.pos_gain = hwdata[15:0];
                `VRC_NGAIN_OFS: nx.neg_gain = hwdata[15:0];
                `VRC_PCOMP_OFS: nx.pos_comp = hwdata[14:0];
                `VRC_NCOMP_OFS: nx.neg_comp = hwdata[14:0];
                `VRC_THR_OFS: nx.thr = hwdata[14:0];
                `VRC_OFFS_OFS: nx.offset = hwdata[15:0];
                `VRC_RPOS_OFS: begin
                    nx.rates[0] = hwdata[15:0];
                    nx.rates[1] = hwdata[31:16];
                end
                `VRC_RNEG_OFS: begin
                    nx.rates[2] = hwdata[15:0];
                    nx.rates[3] = hwdata[31:16];
                end
                `VRC_DITH_OFS: begin
                    nx.dith_amp = hwdata[15:0];
                    nx.dith_half = hwdata[31:16];
                end
                `VRC_LIN_OFS: begin
                    // Index beyond the last breakpoint selects nothing
                    nx.lin_idx = hwdata[`VRC_LIN_IDX +: 4];
                    if (hwdata[`VRC_LIN_IDX +: 4] <= 4'h8) begin
                        nx.lin[hwdata[`VRC_LIN_IDX +: 4]] = hwdata[15:0];
                    end
                end
                `VRC_FBREF_OFS: nx.fb_ref = hwdata[15:0];
                default: nx.wr_pend = nx.wr_pend;
            endcase
        end

        // Stage 1: source select, threshold and compensation
        src = st.src_fb ? st.fb_ref : analog_ref;
        r_in = 32'(signed'(src));
        r_mag = (r_in < 0) ? -r_in : r_in;
        b = r_in;
        if (st.bias_en && r_mag > 32'(st.thr)) begin
            if (r_in < 0) begin
                b = r_in - 32'(st.neg_comp);
            end else begin
                b = r_in + 32'(st.pos_comp);
            end
        end
        nx.s_bias = vrc_sat16(b);

        // Stage 2: gain by sign, then offset
        if (st.s_bias[15]) begin
            prod = 48'(signed'(st.s_bias)) * 48'(st.neg_gain);
        end else begin
            prod = 48'(signed'(st.s_bias)) * 48'(st.pos_gain);
        end
        sc = 32'(prod >>> 15);
        nx.s_scale = vrc_sat16(sc + 32'(signed'(st.offset)));

        // Stage 3: piecewise-linear map on magnitude, sign restored
        x = 32'(signed'(ramp_out));
        xm = (x < 0) ? -x : x;
        k = xm[15:12];
        y0 = st.lin[k];
        y1 = (k >= 4'h8) ? st.lin[8] : st.lin[k + 4'h1];
        ly = signed'(32'(y0)) + ((signed'(32'(y1) - 32'(y0))
            * signed'(32'(xm[11:0]))) >>> 12);
        if (ly > 32'sh00007FFF) begin
            ly = 32'sh00007FFF;
        end
        nx.s_lin = (x < 0) ? 16'(-ly) : 16'(ly);

        // Stage 4: dither, reduced toward full scale
        dm = 32'(signed'(st.s_lin));
        dm = (dm < 0) ? -dm : dm;
        amp_prod = 48'(st.dith_amp) * 48'(32'sh00008000 - dm);
        amp = 32'(amp_prod[46:15]);
        dv = 32'h00000000;
        if (st.dith_en) begin
            dv = st.dith_ph ? amp : -amp;
        end
        nx.cmd = vrc_sat16(32'(signed'(st.s_lin)) + dv);

        // Common slow tick for ramp steps and dither half-periods
        nx.tick = 1'b0;
        if (st.tick_cnt == 8'(TICK_CYC - 1)) begin
            nx.tick_cnt = 8'h00;
            nx.tick = 1'b1;
        end else begin
            nx.tick_cnt = st.tick_cnt + 8'h01;
        end
        if (st.tick) begin
            if (st.dith_cnt + 16'h0001 >= st.dith_half) begin
                nx.dith_cnt = 16'h0000;
                nx.dith_ph = ~st.dith_ph;
            end else begin
                nx.dith_cnt = st.dith_cnt + 16'h0001;
            end
        end

        if (!st.ready) begin
            if (st.pwr_cnt >= 27'(PWRUP_CYCLES - 1)) begin
                nx.ready = 1'b1;
            end else begin
                nx.pwr_cnt = st.pwr_cnt + 27'h0000001;
            end
        end
        // Only the solenoid drive depends on enable and power-up
        nx.sol_en = enable_in & st.ready;
        // Faults ignore enable so disabling never hides one
        nx.fault = sol_short | sol_open | loop_break | xdcr_break;

        case (st.mon_sel)
            VRC_MON_ANALOG: nx.monitor = analog_ref;
            VRC_MON_FIELDBUS: nx.monitor = st.fb_ref;
            VRC_MON_PILOT: nx.monitor = pilot_pos;
            default: nx.monitor = spool_pos;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.pos_gain <= `VRC_GAIN_RST;
            st.neg_gain <= `VRC_GAIN_RST;
            st.pos_comp <= `VRC_COMP_RST;
            st.neg_comp <= `VRC_COMP_RST;
            st.thr <= `VRC_THR_RST;
            st.offset <= `VRC_OFFS_RST;
            st.rates <= {4{`VRC_RATE_RST}};
            st.dith_amp <= `VRC_DAMP_RST;
            st.dith_half <= `VRC_DHALF_RST;
            for (int i = 0; i < 9; i++) begin
                st.lin[i] <= 16'(i * `VRC_LIN_STEP);
            end
        end else begin
            st <= nx;
        end
    end

    vrc_ramp u_ramp (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(st.tick),
        .ramp_en(st.ramp_en),
        .ramp_mode(st.ramp_mode),
        .rate_rise_pos(st.rates[0]),
        .rate_fall_pos(st.rates[1]),
        .rate_rise_neg(st.rates[2]),
        .rate_fall_neg(st.rates[3]),
        .target(st.s_scale),
        .ramp_out(ramp_out)
    );

    // Read data is muxed from registers during the data phase, so a
    // read straight after a write already sees the new value
    always_comb begin
        rd = 32'h00000000;
        case (st.addr)
            `VRC_CTRL_OFS: begin
                rd[`VRC_CTRL_SRC] = st.src_fb;
                rd[`VRC_CTRL_BIAS] = st.bias_en;
                rd[`VRC_CTRL_RAMP] = st.ramp_en;
                rd[`VRC_CTRL_RMODE +: 2] = st.ramp_mode;
                rd[`VRC_CTRL_DITH] = st.dith_en;
                rd[`VRC_CTRL_MON +: 2] = st.mon_sel;
            end
            `VRC_STAT_OFS: rd[7:0] = {xdcr_break, loop_break, sol_open,
                sol_short, st.sol_en, enable_in, st.ready, st.fault};
            `VRC_PGAIN_OFS: rd[15:0] = st.pos_gain;
            `VRC_NGAIN_OFS: rd[15:0] = st.neg_gain;
            `VRC_PCOMP_OFS: rd[14:0] = st.pos_comp;
            `VRC_NCOMP_OFS: rd[14:0] = st.neg_comp;
            `VRC_THR_OFS: rd[14:0] = st.thr;
            `VRC_OFFS_OFS: rd[15:0] = st.offset;
            `VRC_RPOS_OFS: rd = {st.rates[1], st.rates[0]};
            `VRC_RNEG_OFS: rd = {st.rates[3], st.rates[2]};
            `VRC_DITH_OFS: rd = {st.dith_half, st.dith_amp};
            `VRC_LIN_OFS: begin
                rd[`VRC_LIN_IDX +: 4] = st.lin_idx;
                rd[15:0] = (st.lin_idx <= 4'h8) ? st.lin[st.lin_idx] : 16'h0000;
            end
            `VRC_FBREF_OFS: rd[15:0] = st.fb_ref;
            `VRC_CMD_OFS: rd[15:0] = st.cmd;
            default: rd = 32'h00000000;
        endcase
        hrdata = st.rd_pend ? rd : 32'h00000000;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign spool_cmd = st.cmd;
    assign sol_current_en = st.sol_en;
    assign fault_n = ~st.fault;
    assign monitor = st.monitor;
endmodule : vrc_conditioner
`default_nettype wire

// ### verification/vrc_conditioner_monitor.sv
// Port-level assertions for the valve reference conditioner
`timescale 1ns/100ps
`default_nettype none
module vrc_conditioner_monitor
    import vrc_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] analog_ref,
    input wire logic [15:0] spool_pos,
    input wire logic [15:0] pilot_pos,
    input wire logic enable_in,
    input wire logic sol_short,
    input wire logic sol_open,
    input wire logic loop_break,
    input wire logic xdcr_break,
    input wire logic [15:0] spool_cmd,
    input wire logic sol_current_en,
    input wire logic fault_n,
    input wire logic [15:0] monitor
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_ph;
    logic wr_ph;
    logic [7:0] ph_addr;
    logic [1:0] mon_sel;
    logic [15:0] fb;
    logic [15:0] exp_mon;
    logic [31:0] up_cnt;
    // Shadow of the monitor select and fieldbus value, decoded off the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_addr <= 8'h00;
            mon_sel <= 2'h0;
            fb <= 16'h0000;
            up_cnt <= 32'h0;
        end else begin
            rd_ph <= hsel & htrans[1] & hready & ~hwrite
                & (haddr[31:8] == 24'h0);
            wr_ph <= hsel & htrans[1] & hready & hwrite;
            ph_addr <= haddr[7:0];
            up_cnt <= (up_cnt == 32'hFFFFFFFF) ? up_cnt : up_cnt + 32'h1;
            if (wr_ph && ph_addr == 8'h00) begin
                mon_sel <= hwdata[7:6];
            end
            if (wr_ph && ph_addr == 8'h30) begin
                fb <= hwdata[15:0];
            end
        end
    end
    assign exp_mon = (mon_sel == 2'h0) ? spool_pos : (mon_sel == 2'h1) ?
        analog_ref : (mon_sel == 2'h2) ? fb : pilot_pos;
    fault_out_a:
        assert property ($past(hresetn) |-> fault_n ==
            !$past(sol_short | sol_open | loop_break | xdcr_break))
        else $error("fault output does not follow the fault sources");
    sol_off_a:
        assert property (!enable_in |=> !sol_current_en)
        else $error("solenoid current on while disabled");
    pwrup_hold_a:
        assert property (up_cnt < PWRUP_CYCLES |-> !sol_current_en)
        else $error("solenoid current on during power-up");
    sol_on_a:
        assert property (enable_in && up_cnt > PWRUP_CYCLES + 4
            |=> sol_current_en)
        else $error("solenoid current not on when enabled");
    monitor_sel_a:
        assert property ($past(hresetn) |-> monitor == $past(exp_mon))
        else $error("monitor shows the wrong source");
    rd_idle_a:
        assert property (!rd_ph |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    cmd_read_a:
        assert property (rd_ph && ph_addr == 8'h34 |->
            hrdata[15:0] == spool_cmd)
        else $error("command readback differs from output");
    bus_okay_a:
        assert property (hsel && htrans[1] |-> hreadyout && !hresp ##1
            (hreadyout && !hresp))
        else $error("bus answer not ready and okay");
    cover property ($fell(fault_n));
    cover property ($rose(sol_current_en));
    cover property (rd_ph && ph_addr == 8'h34);
    cover property (mon_sel == 2'h3 && monitor == $past(pilot_pos));
endmodule : vrc_conditioner_monitor
bind vrc_conditioner vrc_conditioner_monitor #(
    .PWRUP_CYCLES(PWRUP_CYCLES)
) i_vrc_conditioner_monitor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_ref(analog_ref), .spool_pos(spool_pos), .pilot_pos(pilot_pos),
    .enable_in(enable_in), .sol_short(sol_short), .sol_open(sol_open),
    .loop_break(loop_break), .xdcr_break(xdcr_break),
    .spool_cmd(spool_cmd), .sol_current_en(sol_current_en),
    .fault_n(fault_n), .monitor(monitor)
);
`default_nettype wire

// ### verification/vrc_ctrl_model.sv
// Machine controller model: drives reference and enable, watches fault
`timescale 1ns/100ps
`default_nettype none
module vrc_ctrl_model (
    input wire logic hclk,
    input wire logic fault_n,
    output logic [15:0] analog_ref,
    output logic enable_in,
    output logic [7:0] fault_seen
);
    logic fault_prev = 1'b1;
    initial begin
        analog_ref = 16'h0000;
        enable_in = 1'b1;
        fault_seen = 8'h00;
    end
    // Counts fault reports; a level check alone would miss short glitches
    always @(posedge hclk) begin
        if (fault_prev === 1'b1 && fault_n === 1'b0) begin
            fault_seen <= fault_seen + 8'h01;
        end
        fault_prev <= fault_n;
    end
    task automatic set_ref(input logic [15:0] v);
        @(posedge hclk);
        analog_ref <= v;
    endtask : set_ref
    task automatic set_en(input logic v);
        @(posedge hclk);
        enable_in <= v;
    endtask : set_en
endmodule : vrc_ctrl_model
`default_nettype wire

// ### verification/test_vrc_conditioner.sv
// Self-checking bench for the valve reference conditioner
`timescale 1ns/100ps
`default_nettype none
module test_vrc_conditioner;
    localparam int unsigned PWRUP = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] spool_pos = 16'h1357;
    logic [15:0] pilot_pos = 16'h2468;
    logic [3:0] flt = 4'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [15:0] analog_ref;
    logic enable_in;
    logic [15:0] spool_cmd;
    logic sol_current_en;
    logic fault_n;
    logic [15:0] monitor;
    logic [7:0] fault_seen;
    logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h0C, 8'h18, 8'h1C, 8'h24, 8'h28};
    logic [31:0] rv [7] = '{32'h0, 32'h8000, 32'h8000, 32'h0, 32'h0,
        32'h01000100, 32'h00040100};
    int fails = 0;
    int total_checks = 0;
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    vrc_conditioner #(.PWRUP_CYCLES(PWRUP)) i_vrc_conditioner (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .analog_ref(analog_ref), .spool_pos(spool_pos),
        .pilot_pos(pilot_pos), .enable_in(enable_in), .sol_short(flt[0]),
        .sol_open(flt[1]), .loop_break(flt[2]), .xdcr_break(flt[3]),
        .spool_cmd(spool_cmd), .sol_current_en(sol_current_en),
        .fault_n(fault_n), .monitor(monitor)
    );
    vrc_ctrl_model i_vrc_ctrl_model (
        .hclk(hclk), .fault_n(fault_n), .analog_ref(analog_ref),
        .enable_in(enable_in), .fault_seen(fault_seen)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time,
                seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("Checks made %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    // Outputs are sampled at the falling edge, clear of register updates
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask : wait_cyc
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        q = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic rc(input logic [15:0] r, input int n,
            input logic [15:0] e);
        i_vrc_ctrl_model.set_ref(r);
        wait_cyc(n);
        chk({16'h0, spool_cmd}, {16'h0, e});
    endtask : rc
    task automatic dith(input logic [15:0] r, input logic [15:0] a);
        int hi = 0;
        int lo = 0;
        int bad = 0;
        i_vrc_ctrl_model.set_ref(r);
        wait_cyc(10);
        repeat (600) begin
            wait_cyc(0);
            if (spool_cmd === r + a) begin
                hi++;
            end else if (spool_cmd === r - a) begin
                lo++;
            end else begin
                bad++;
            end
        end
        chk({31'h0, hi > 0 && lo > 0 && bad == 0}, 32'h1);
    endtask : dith
    initial begin
        repeat (40000) @(posedge hclk);
        fails++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        wait_cyc(10);
        chk(sol_current_en, 32'h0);
        wait_cyc(20);
        chk(sol_current_en, 32'h1);
        foreach (ra[i]) begin
            rd(ra[i], rv[i]);
        end
        wr(8'h40, 32'hFFFF);
        rd(8'h40, 32'h0);
        i_vrc_ctrl_model.set_ref(16'h1234);
        wait_cyc(4);
        chk(spool_cmd, 32'h0);
        wait_cyc(1);
        chk(spool_cmd, 32'h1234);
        rd(8'h34, 32'h1234);
        wr(8'h08, 32'h4000);
        wr(8'h0C, 32'h2000);
        rc(16'h2000, 8, 16'h1000);
        rc(16'hE000, 8, 16'hF800);
        wr(8'h08, 32'h8000);
        wr(8'h0C, 32'h8000);
        wr(8'h18, 32'h100);
        wr(8'h10, 32'h50);
        wr(8'h14, 32'h30);
        wr(8'h00, 32'h2);
        rc(16'h0100, 8, 16'h0100);
        rc(16'hFF00, 8, 16'hFF00);
        rc(16'h0101, 8, 16'h0151);
        rc(16'hFE00, 8, 16'hFDD0);
        wr(8'h1C, 32'h40);
        rc(16'h0101, 8, 16'h0191);
        wr(8'h08, 32'h4000);
        rc(16'h0101, 8, 16'h00E8);
        wr(8'h08, 32'h8000);
        wr(8'h1C, 32'h0);
        wr(8'h00, 32'h0);
        rc(16'h0000, 8, 16'h0000);
        // Rates chosen so that each mode settles after a distinct number of ticks
        wr(8'h20, 32'h02000100);
        wr(8'h24, 32'h01000800);
        wr(8'h00, 32'h04);
        i_vrc_ctrl_model.set_ref(16'h1000);
        wait_cyc(300);
        chk({31'h0, spool_cmd != 16'h0 && spool_cmd < 16'h1000}, 1);
        wait_cyc(4000);
        chk(spool_cmd, 32'h1000);
        wr(8'h00, 32'h0C);
        rc(16'h0000, 2040, 16'h0000);
        wr(8'h00, 32'h14);
        rc(16'hF000, 790, 16'hF000);
        wr(8'h00, 32'h1C);
        rc(16'hE000, 540, 16'hE000);
        wr(8'h00, 32'h0);
        rc(16'h1000, 8, 16'h1000);
        wr(8'h28, 32'h00010100);
        wr(8'h00, 32'h20);
        dith(16'h0000, 16'h0100);
        dith(16'h6000, 16'h0040);
        wr(8'h00, 32'h0);
        i_vrc_ctrl_model.set_en(1'b0);
        wait_cyc(2);
        chk(sol_current_en, 32'h0);
        rc(16'h0100, 8, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            flt <= 4'h1 << i;
            wait_cyc(2);
            chk(fault_n, 32'h0);
            rd(8'h04, 32'h3 | (32'h10 << i));
            @(posedge hclk);
            flt <= 4'h0;
            wait_cyc(2);
            chk(fault_n, 32'h1);
        end
        chk(fault_seen, 32'h4);
        @(posedge hclk);
        flt <= 4'h8;
        i_vrc_ctrl_model.set_en(1'b1);
        wait_cyc(3);
        chk(fault_n, 32'h0);
        chk(sol_current_en, 32'h1);
        @(posedge hclk);
        flt <= 4'h0;
        wr(8'h18, 32'h0);
        wr(8'h30, 32'h0ABC);
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, {24'h0, s[1:0], 6'h01});
            wait_cyc(8);
            chk(spool_cmd, 32'h0ABC);
            chk(monitor, (s == 0) ? 16'h1357 : (s == 1) ? 16'h0100 :
                (s == 2) ? 16'h0ABC : 16'h2468);
        end
        end_sim();
    end
endmodule : test_vrc_conditioner
`default_nettype wire
